/* logic/quadrature_counter_channel.sv */
// quadrature position counter channel with its four host registers
//
// Operation
// - a readback read returns the live counter value; register is read-only
// - constant A is write-only, 16/32-bit writes; 32-bit channel needs one full write
// - constant B is read/write and taken whole in one clock as the size demands
// - reset clears the setup register; 8, 16 and 32-bit accesses allowed
// - setup bit 14 selects 32-bit counting, configured via the lower channel
// - system or software reset clears both constant registers
// - mode field 001 runs the channel as a quadrature position counter
// - count up when A leads B, down when B leads A
// - single rate: up on A rising while A leads, down on A falling otherwise
// - double rate: one step on every edge of A
// - quadruple rate: one step on every edge of A and of B
// - bits 5:4 select A use: off, single, double, quadruple rate
// - phase B is used only while bit 6 is set
// - counting starts only after a software trigger
// - under the index-with-reload condition, index high in the selected phase reloads the counter with constant B
// - interrupt on index (with or without reload) or on count equal to constant A, picked by bits 11:10
// - interrupt only with bit 15 set and the board interrupt enable set
// - interrupt stays pending until cleared by status write or bit 15 cleared
// - bit 3 sets output active level: 0 low, 1 high
// - index phase codes 001..100 select a phase; others disable reload
// - condition codes: none, equal A, index with reload, index without reload
// - output active while count equals A, or while index condition holds
// - bit 13 rejects input pulses of 2.4 us or less
`timescale 1ns/1ps
`default_nettype none

module quadrature_counter_channel
  import quad_counter_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sw_reset,
  input wire host_req_s host_req,
  output host_rsp_s host_rsp,
  input wire logic trigger,
  input wire logic irq_clear,
  input wire logic board_irq_en,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  output logic out_level,
  output logic out_oe_n,
  output logic irq_pending
);

  // byte-enable merge used by every writable register
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // narrow to the selected counter size
  function automatic logic [CNT_W-1:0] size_fit(input logic [CNT_W-1:0] v, input logic wide);
    return wide ? v : {{(CNT_W-16){1'b0}}, v[15:0]};
  endfunction

  // ---------------- input conditioning
  logic [2:0] raw_in;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg;
  logic [2:0] agreed_reg, agreed_next;
  logic [2:0] clean_reg, clean_next;
  logic [DEB_W-1:0] deb_cnt_reg [3];
  logic [DEB_W-1:0] deb_cnt_next [3];

  // ---------------- registers and counter
  logic [15:0] setup_reg, setup_next;
  logic [31:0] const_a_reg, const_a_next;
  logic [31:0] const_b_reg, const_b_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic running_reg, running_next;
  logic [1:0] prev_ab_reg, prev_ab_next;
  logic hit_reg, hit_next;
  logic eq_reg, eq_next;
  logic pend_reg, pend_next;
  logic out_level_reg, out_level_next;
  logic out_oe_n_reg, out_oe_n_next;
  host_rsp_s rsp_reg, rsp_next;

  assign raw_in = {index_input, phase_b_input, phase_a_input};

  always_comb begin
    agreed_next = agreed_reg;
    clean_next = clean_reg;
    for (int i = 0; i < 3; i++) begin
      deb_cnt_next[i] = deb_cnt_reg[i];
      if (sync2_reg[i] == sync3_reg[i]) begin
        agreed_next[i] = sync3_reg[i];
      end
      if (!setup_reg[DEB_EN_BIT]) begin
        clean_next[i] = agreed_reg[i];
        deb_cnt_next[i] = '0;
      end else if (agreed_reg[i] == clean_reg[i]) begin
        deb_cnt_next[i] = '0;
      end else if (deb_cnt_reg[i] >= DEB_ACCEPT - 1'b1) begin
        // level held past the reject window, so accept it
        clean_next[i] = agreed_reg[i];
        deb_cnt_next[i] = '0;
      end else begin
        deb_cnt_next[i] = deb_cnt_reg[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      agreed_reg <= 3'h0;
      clean_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        deb_cnt_reg[i] <= '0;
      end
    end else if (clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      agreed_reg <= agreed_next;
      clean_reg <= clean_next;
      for (int i = 0; i < 3; i++) begin
        deb_cnt_reg[i] <= deb_cnt_next[i];
      end
    end
  end

  // ---------------- decode of setup fields
  logic quad_mode, wide, b_en, idx_phase_ok, idx_match, cnt_eq_a;
  logic a_edge, b_edge, up_a, up_b, step, step_up, idx_rise, eq_rise;
  logic [1:0] ab;
  logic [2:0] idx_sel;
  rate_e rate;
  cond_e cond;
  logic full_word, low_half, const_wr_ok;
  logic [31:0] setup_merged;

  always_comb begin
    quad_mode = setup_reg[MODE_LSB +: 3] == MODE_QUAD;
    wide = setup_reg[SIZE32_BIT];
    b_en = setup_reg[B_EN_BIT];
    rate = rate_e'(setup_reg[RATE_LSB +: 2]);
    cond = cond_e'(setup_reg[COND_LSB +: 2]);
    idx_sel = setup_reg[IDX_LSB +: 3];
    // disabled B reads as a steady low
    ab = {clean_reg[1] & b_en, clean_reg[0]};
    a_edge = ab[0] != prev_ab_reg[0];
    b_edge = (ab[1] != prev_ab_reg[1]) && b_en;
    up_a = ab[0] != ab[1];
    up_b = ab[1] == ab[0];
    step = 1'b0;
    step_up = 1'b0;
    unique case (rate)
      RATE_OFF: begin
        step = 1'b0;
      end
      RATE_X1: begin
        // rising A while A leads, falling A while B leads
        step = a_edge && (ab[0] == up_a);
        step_up = up_a;
      end
      RATE_X2: begin
        step = a_edge;
        step_up = up_a;
      end
      RATE_X4: begin
        step = a_edge || b_edge;
        step_up = a_edge ? up_a : up_b;
      end
    endcase
    idx_phase_ok = 1'b1;
    idx_match = 1'b0;
    unique case (idx_sel)
      3'h1: idx_match = !ab[0] && ab[1];
      3'h2: idx_match = ab[0] && !ab[1];
      3'h3: idx_match = ab[0] && ab[1];
      3'h4: idx_match = !ab[0] && !ab[1];
      default: idx_phase_ok = 1'b0;
    endcase
    // relies on index covering part of the phase for the match to appear
    hit_next = quad_mode && running_reg && idx_phase_ok && idx_match && clean_reg[2];
    idx_rise = hit_next && !hit_reg;
    cnt_eq_a = size_fit(count_reg, wide) == size_fit(CNT_W'(const_a_reg), wide);
    eq_next = quad_mode && running_reg && cnt_eq_a;
    eq_rise = eq_next && !eq_reg;
  end

  // ---------------- host access qualification
  always_comb begin
    full_word = host_req.be == 4'hf;
    low_half = host_req.be == 4'h3;
    // a 32-bit channel takes its constants only from a full-word write
    const_wr_ok = full_word || (low_half && !setup_reg[SIZE32_BIT]);
  end

  // ---------------- register file, counter, interrupt and output
  always_comb begin
    setup_next = setup_reg;
    const_a_next = const_a_reg;
    const_b_next = const_b_reg;
    count_next = count_reg;
    running_next = running_reg;
    prev_ab_next = ab;
    pend_next = pend_reg;
    rsp_next.rvalid = host_req.rd;
    rsp_next.rdata = rsp_reg.rdata;
    // setup lives in the low half, so only the low two lanes matter
    setup_merged = merge_be({16'h0000, setup_reg}, host_req.wdata, {2'b00, host_req.be[1:0]});

    if (host_req.wr) begin
      unique case (host_req.sel)
        OFS_LIVE_COUNT: begin
          setup_next = setup_reg;
        end
        OFS_INITIAL_COUNT: begin
          if (const_wr_ok) begin
            const_a_next = merge_be(const_a_reg, host_req.wdata, host_req.be);
          end
        end
        OFS_RELOAD_COUNT: begin
          if (const_wr_ok) begin
            const_b_next = merge_be(const_b_reg, host_req.wdata, host_req.be);
          end
        end
        OFS_CHANNEL_SETUP: begin
          setup_next = setup_merged[15:0] & SETUP_WMASK;
        end
      endcase
    end

    if (host_req.rd) begin
      unique case (host_req.sel)
        OFS_LIVE_COUNT: rsp_next.rdata = 32'(size_fit(count_reg, wide));
        OFS_INITIAL_COUNT: rsp_next.rdata = 32'h0000_0000;
        OFS_RELOAD_COUNT: rsp_next.rdata = const_b_reg;
        OFS_CHANNEL_SETUP: rsp_next.rdata = {16'h0000, setup_reg};
      endcase
    end

    if (!quad_mode) begin
      running_next = 1'b0;
    end else if (trigger) begin
      // start from the initial value on the software trigger
      running_next = 1'b1;
      count_next = size_fit(CNT_W'(const_a_reg), wide);
    end else if (running_reg) begin
      if (idx_rise && cond == COND_IDX_RELOAD) begin
        count_next = size_fit(CNT_W'(const_b_reg), wide);
      end else if (step) begin
        count_next = size_fit(step_up ? count_reg + 1'b1 : count_reg - 1'b1, wide);
      end
    end

    // set wins over clear in the same cycle
    if (irq_clear || !setup_reg[IRQ_EN_BIT]) begin
      pend_next = 1'b0;
    end
    if (setup_reg[IRQ_EN_BIT] && board_irq_en) begin
      if ((cond == COND_EQ_A && eq_rise) || (cond[1] && idx_rise)) begin
        pend_next = 1'b1;
      end
    end

    out_oe_n_next = !((cond == COND_EQ_A && eq_next) || (cond[1] && hit_next));
    out_level_next = out_oe_n_next ? 1'b1 : setup_reg[POL_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      setup_reg <= SETUP_RESET;
      const_a_reg <= CONST_RESET;
      const_b_reg <= CONST_RESET;
      count_reg <= '0;
      running_reg <= 1'b0;
      prev_ab_reg <= 2'b00;
      hit_reg <= 1'b0;
      eq_reg <= 1'b0;
      pend_reg <= 1'b0;
      out_level_reg <= 1'b1;
      out_oe_n_reg <= 1'b1;
      rsp_reg <= '0;
    end else if (clk_en) begin
      if (sw_reset) begin
        setup_reg <= SETUP_RESET;
        const_a_reg <= CONST_RESET;
        const_b_reg <= CONST_RESET;
        count_reg <= '0;
        running_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        setup_reg <= setup_next;
        const_a_reg <= const_a_next;
        const_b_reg <= const_b_next;
        count_reg <= count_next;
        running_reg <= running_next;
        pend_reg <= pend_next;
      end
      prev_ab_reg <= prev_ab_next;
      hit_reg <= hit_next;
      eq_reg <= eq_next;
      out_level_reg <= out_level_next;
      out_oe_n_reg <= out_oe_n_next;
      rsp_reg <= rsp_next;
    end
  end

  assign host_rsp = rsp_reg;
  assign out_level = out_level_reg;
  assign out_oe_n = out_oe_n_reg;
  assign irq_pending = pend_reg;

endmodule

`default_nettype wire

/* logic/quad_counter_pkg.sv */
// constants and types shared by the quadrature counter channel
package quad_counter_pkg;
  localparam int CLK_MHZ = 40;
  localparam int DEBOUNCE_NS = 2400;
  // pulses of the debounce time or less are rejected, so one cycle more is needed
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS * CLK_MHZ) / 1000;
  localparam int DEB_W = 8;
  localparam logic [DEB_W-1:0] DEB_ACCEPT = DEB_W'(DEBOUNCE_CYCLES + 1);

  localparam logic [1:0] OFS_LIVE_COUNT = 2'h0;
  localparam logic [1:0] OFS_INITIAL_COUNT = 2'h1;
  localparam logic [1:0] OFS_RELOAD_COUNT = 2'h2;
  localparam logic [1:0] OFS_CHANNEL_SETUP = 2'h3;

  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [31:0] CONST_RESET = 32'h0000_0000;
  localparam logic [15:0] SETUP_WMASK = 16'hefff;

  localparam int MODE_LSB = 0;
  localparam int POL_BIT = 3;
  localparam int RATE_LSB = 4;
  localparam int B_EN_BIT = 6;
  localparam int IDX_LSB = 7;
  localparam int COND_LSB = 10;
  localparam int DEB_EN_BIT = 13;
  localparam int SIZE32_BIT = 14;
  localparam int IRQ_EN_BIT = 15;

  localparam logic [2:0] MODE_QUAD = 3'h1;

  typedef enum logic [1:0] {
    RATE_OFF = 2'b00,
    RATE_X1 = 2'b01,
    RATE_X2 = 2'b10,
    RATE_X4 = 2'b11
  } rate_e;

  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ_A = 2'b01,
    COND_IDX_RELOAD = 2'b10,
    COND_IDX_ONLY = 2'b11
  } cond_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] sel;
    logic [3:0] be;
    logic [31:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } host_rsp_s;
endpackage

/* tb/quad_counter_checker.sv */
// port-level assertions for the quadrature counter channel
`timescale 1ns/1ps
`default_nettype none
module quad_counter_checker
  import quad_counter_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sw_reset,
  input wire host_req_s host_req,
  input wire host_rsp_s host_rsp,
  input wire logic trigger,
  input wire logic irq_clear,
  input wire logic board_irq_en,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic out_level,
  input wire logic out_oe_n,
  input wire logic irq_pending
);
  logic en15_reg;
  logic en15_next;
  logic rd_take;
  assign rd_take = clk_en && host_req.rd;
  // shadow of the interrupt enable bit, seen only through host writes
  always_comb begin
    en15_next = en15_reg;
    if (!nrst || sw_reset) begin
      en15_next = 1'b0;
    end else if (host_req.wr && host_req.sel == OFS_CHANNEL_SETUP && host_req.be[1]) begin
      en15_next = host_req.wdata[IRQ_EN_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      en15_reg <= en15_next;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence rd_seq;
    rd_take;
  endsequence
  sequence en_off_seq;
    !en15_reg ##1 !en15_reg;
  endsequence
  AST_RD_ANSWER: assert property (rd_seq |=> host_rsp.rvalid)
    else $error("read not answered next cycle");
  AST_RV_CAUSE: assert property (host_rsp.rvalid |-> $past(rd_take))
    else $error("read answer without request");
  AST_RDATA_HOLD: assert property (!host_rsp.rvalid |-> $stable(host_rsp.rdata))
    else $error("read data moved without a read");
  AST_RESET_OUT: assert property ($rose(nrst) |-> out_oe_n && !irq_pending)
    else $error("outputs not idle after reset");
  AST_PULLUP: assert property (out_oe_n |-> out_level)
    else $error("released pin not high");
  AST_IRQ_GATE: assert property ($rose(irq_pending) |-> $past(board_irq_en) && $past(en15_reg))
    else $error("interrupt raised while disabled");
  AST_IRQ_HOLD: assert property (irq_pending && !irq_clear && !sw_reset && en15_reg && en15_next
    |=> irq_pending)
    else $error("pending dropped without release");
  AST_IRQ_OFF: assert property (en_off_seq |-> !irq_pending)
    else $error("pending with enable bit clear");
  AST_SW_RESET: assert property (sw_reset && clk_en |=> !irq_pending ##1 out_oe_n)
    else $error("software reset left channel active");
endmodule
bind quadrature_counter_channel quad_counter_checker #(.CNT_W(CNT_W)) i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .sw_reset(sw_reset),
  .host_req(host_req), .host_rsp(host_rsp), .trigger(trigger), .irq_clear(irq_clear),
  .board_irq_en(board_irq_en), .phase_a_input(phase_a_input),
  .phase_b_input(phase_b_input), .index_input(index_input), .out_level(out_level),
  .out_oe_n(out_oe_n), .irq_pending(irq_pending));
`default_nettype wire

/* tb/encoder_model.sv */
// behavioural quadrature encoder with index channel
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic clk_sys,
  input wire logic step,
  input wire logic fwd,
  input wire logic idx_on,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  logic [1:0] pos_reg = 2'h0;
  always_ff @(posedge clk_sys) begin
    if (step) begin
      pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end
  end
  // forward walks 00,10,11,01 so a leads b
  assign phase_a = pos_reg[1] ^ pos_reg[0];
  assign phase_b = pos_reg[1];
  // index held over the whole a=1 b=1 phase
  assign index = idx_on && pos_reg == 2'h2;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// register-level testbench for the quadrature counter channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import quad_counter_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sw_reset = 1'b0;
  logic trigger = 1'b0;
  logic irq_clear = 1'b0;
  logic board_irq_en = 1'b0;
  logic step = 1'b0;
  logic fwd = 1'b1;
  logic idx_on = 1'b0;
  logic pa;
  logic pb;
  logic pi;
  logic out_level;
  logic out_oe_n;
  logic irq_pending;
  host_req_s req = '0;
  host_rsp_s rsp;
  int error_cnt = 0;
  int compares = 0;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  quadrature_counter_channel #(.CNT_W(32)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .sw_reset(sw_reset),
    .host_req(req), .host_rsp(rsp), .trigger(trigger), .irq_clear(irq_clear),
    .board_irq_en(board_irq_en), .phase_a_input(pa), .phase_b_input(pb),
    .index_input(pi), .out_level(out_level), .out_oe_n(out_oe_n),
    .irq_pending(irq_pending));
  encoder_model i_enc (.clk_sys(clk_sys), .step(step), .fwd(fwd), .idx_on(idx_on),
    .phase_a(pa), .phase_b(pb), .index(pi));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_sys);
    req.wr <= 1'b1;
    req.sel <= s;
    req.be <= b;
    req.wdata <= d;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [31:0] e);
    @(posedge clk_sys);
    req.rd <= 1'b1;
    req.sel <= s;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk({31'h0, rsp.rvalid}, 32'h1);
    chk(rsp.rdata, e);
  endtask
  // the encoder moves slowly enough for the input synchronisers
  task automatic steps(input int n, input logic f);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_sys);
      step <= 1'b1;
      fwd <= f;
      @(posedge clk_sys);
      step <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task automatic pulse_trig();
    @(posedge clk_sys);
    trigger <= 1'b1;
    @(posedge clk_sys);
    trigger <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic final_report();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(OFS_CHANNEL_SETUP, 32'h0);
    rd(OFS_RELOAD_COUNT, 32'h0);
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'hffff);
    rd(OFS_CHANNEL_SETUP, 32'hefff);
    wr(OFS_CHANNEL_SETUP, 4'h1, 32'h0);
    rd(OFS_CHANNEL_SETUP, 32'hef00);
    wr(OFS_INITIAL_COUNT, 4'hf, 32'h10);
    rd(OFS_INITIAL_COUNT, 32'h0);
    wr(OFS_RELOAD_COUNT, 4'hf, 32'h1234);
    wr(OFS_RELOAD_COUNT, 4'h1, 32'hff);
    rd(OFS_RELOAD_COUNT, 32'h1234);
    for (int i = 1; i < 4; i++) begin
      wr(OFS_CHANNEL_SETUP, 4'h3, {25'h0, 1'b1, 2'(i), 4'h1});
      pulse_trig();
      rd(OFS_LIVE_COUNT, 32'h10);
      steps(4, 1'b1);
      rd(OFS_LIVE_COUNT, 32'h10 + 32'((i == 3) ? 4 : i));
      steps(4, 1'b0);
      rd(OFS_LIVE_COUNT, 32'h10);
    end
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'h4071);
    wr(OFS_INITIAL_COUNT, 4'hf, 32'h12345678);
    wr(OFS_INITIAL_COUNT, 4'h3, 32'h5);
    pulse_trig();
    rd(OFS_LIVE_COUNT, 32'h12345678);
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'h0071);
    pulse_trig();
    rd(OFS_LIVE_COUNT, 32'h5678);
    board_irq_en <= 1'b1;
    idx_on <= 1'b1;
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'h89f9);
    pulse_trig();
    steps(2, 1'b1);
    chk({31'h0, irq_pending}, 32'h1);
    chk({30'h0, out_oe_n, out_level}, 32'h1);
    rd(OFS_LIVE_COUNT, 32'h1234);
    irq_clear <= 1'b1;
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_pending}, 32'h0);
    idx_on <= 1'b0;
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'h8479);
    pulse_trig();
    chk({31'h0, irq_pending}, 32'h1);
    chk({30'h0, out_oe_n, out_level}, 32'h1);
    steps(1, 1'b1);
    chk({31'h0, out_oe_n}, 32'h1);
    wr(OFS_CHANNEL_SETUP, 4'h3, 32'h0479);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq_pending}, 32'h0);
    sw_reset <= 1'b1;
    @(posedge clk_sys);
    sw_reset <= 1'b0;
    rd(OFS_RELOAD_COUNT, 32'h0);
    rd(OFS_CHANNEL_SETUP, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
